// [core/cfg_store.sv]
// Small configuration memory, registered read data.
// Assumes one clock and a synchronous clear from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module cfg_store
	import strap_pkg::*;
#(
	parameter int unsigned WORDS = CFG_WORDS,
	parameter int unsigned AW    = CFG_AW
) (
	input  wire logic          clk_sys,
	input  wire logic          clear,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data
);
	logic [7:0] mem_reg [WORDS];

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < WORDS; i++) begin
			if (clear)
				mem_reg[i] <= CFG_RESET_VAL;
			else if (wr_en && wr_addr == AW'(i))
				mem_reg[i] <= wr_data;
		end
		rd_data <= mem_reg[rd_addr];
	end
endmodule
`default_nettype wire

// [core/reset_strap_iface_select.sv]
// Restart, power-on reset, strap capture, pin muxing, reference inputs.
// Assumes pins synchronous to clk_sys; flash is an external save port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - The device resets itself at power-up without any restart pulse.
// - An undriven restart input reads high, meaning normal operation.
// - Strap open gives UART plus I2C slave, strap low gives one SPI port.
// - In SPI mode the I2C clock, UART transmit and receive pins carry clock, MISO, MOSI.
// - Each reference input has its offset to the sync source measured and reported.
// - The reference inputs can also act as external interrupt inputs.
// - A buffered reference clock comes from the disciplined oscillator.
// - A low timepulse pin at reset selects recovery boot.
// - Config changes last until reset unless saved to flash by command.
module reset_strap_iface_select
	import strap_pkg::*;
#(
	parameter int unsigned RESTART_CYC = RESTART_MIN_CYC,
	parameter int unsigned POR_CYC     = POR_HOLD_CYC
) (
	input  wire logic               clk_sys,
	input  wire logic               rst_b,
	input  wire logic               restart_in_b,
	input  wire logic               iface_sel_strap_b,
	input  wire logic               pulse_output_two_in,
	input  wire logic               pulse_gen,
	output logic                    pulse_output_two_out,
	output logic                    pulse_output_two_oe,
	input  wire logic               sync_pulse,
	input  wire logic               ref_pulse_in_a,
	input  wire logic               ref_pulse_in_b,
	input  wire logic               irq_mode,
	input  wire logic               steer_en,
	output logic [PHASE_W-1:0]      offset_a,
	output logic [PHASE_W-1:0]      offset_b,
	output logic                    offset_valid,
	output logic                    steer_a,
	output logic                    steer_b,
	output logic                    ext_irq_a,
	output logic                    ext_irq_b,
	input  wire logic               osc_clk_en,
	output logic                    disciplined_clk_out,
	input  wire logic               i2c_scl_in,
	input  wire logic               uart_rx_in,
	input  wire logic               i2c_sda_in,
	input  wire logic               uart_tx_core,
	input  wire logic               spi_miso_core,
	output logic                    uart_tx_pin,
	output logic                    uart_tx_oe,
	output logic                    uart_rx_core,
	output logic                    i2c_scl_core,
	output logic                    i2c_sda_core,
	output logic                    i2c_port_en,
	output logic                    uart_en,
	output logic                    spi_sclk,
	output logic                    spi_mosi,
	output logic                    spi_cs_b,
	output logic                    spi_en,
	input  wire cfg_cmd_t           cfg_cmd,
	input  wire logic [CFG_AW-1:0]  cfg_rd_addr,
	output logic      [7:0]         cfg_rd_data,
	output logic                    save_config_command,
	output logic                    core_rst_b,
	output logic                    recovery_boot,
	output logic                    spi_mode
);
	// ==================================================
	// Reset release and power-on
	logic       rst_s1_reg;
	logic       rst_s2_reg;
	logic       rst_int_b;
	logic       rin_s1_reg;
	logic       rin_s2_reg;
	logic [$clog2(RESTART_CYC+1)-1:0] low_cnt_reg;
	logic [$clog2(POR_CYC+1)-1:0]     por_cnt_reg;
	seq_state_t state_reg;
	seq_state_t state_next;
	strap_t     strap_reg;
	wire        restart_hit;
	wire        por_done;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_int_b = rst_s2_reg;

	// Restart input, pulled high when open
	always_ff @(posedge clk_sys or negedge rst_int_b) begin
		if (!rst_int_b) begin
			rin_s1_reg <= 1'b1;
			rin_s2_reg <= 1'b1;
		end else begin
			rin_s1_reg <= restart_in_b;
			rin_s2_reg <= rin_s1_reg;
		end
	end

	// Low-width filter
	always_ff @(posedge clk_sys or negedge rst_int_b) begin
		if (!rst_int_b)
			low_cnt_reg <= '0;
		else if (rin_s2_reg)
			low_cnt_reg <= '0;
		else if (!restart_hit)
			low_cnt_reg <= low_cnt_reg + 1'b1;
	end
	assign restart_hit = (low_cnt_reg == ($bits(low_cnt_reg))'(RESTART_CYC));

	always_ff @(posedge clk_sys or negedge rst_int_b) begin
		if (!rst_int_b)
			por_cnt_reg <= '0;
		else if (state_reg == ST_POR || state_reg == ST_HOLD)
			por_cnt_reg <= por_done ? por_cnt_reg : por_cnt_reg + 1'b1;
		else
			por_cnt_reg <= '0;
	end
	assign por_done = (por_cnt_reg == ($bits(por_cnt_reg))'(POR_CYC));

	// ==================================================
	// Sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_POR: begin
				// Restart pin held low at power-up keeps the core in reset
				if (por_done && rin_s2_reg)
					state_next = ST_STRAP;
			end
			ST_STRAP: begin
				state_next = ST_RUN;
			end
			ST_RUN: begin
				if (restart_hit)
					state_next = ST_HOLD;
			end
			ST_HOLD: begin
				if (rin_s2_reg && por_done)
					state_next = ST_STRAP;
			end
			default: begin
				state_next = ST_POR;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_int_b) begin
		if (!rst_int_b)
			state_reg <= ST_POR;
		else
			state_reg <= state_next;
	end

	// Straps caught on each release, after power-on and after every restart hold
	always_ff @(posedge clk_sys or negedge rst_int_b) begin
		if (!rst_int_b)
			strap_reg <= '0;
		else if (state_reg == ST_STRAP) begin
			strap_reg.spi_mode      <= !iface_sel_strap_b;
			strap_reg.recovery_boot <= !pulse_output_two_in;
		end
	end

	wire running = (state_reg == ST_RUN);
	assign core_rst_b    = running;
	assign recovery_boot = strap_reg.recovery_boot;
	assign spi_mode      = strap_reg.spi_mode;

	// Timepulse pin released outside run so the strap floats high
	assign pulse_output_two_oe  = running;
	assign pulse_output_two_out = running & pulse_gen;

	// ==================================================
	// Shared interface pins
	assign uart_en      = running & !spi_mode;
	assign i2c_port_en  = running & !spi_mode;
	assign spi_en       = running & spi_mode;
	assign spi_sclk     = spi_mode & i2c_scl_in;
	assign spi_mosi     = spi_mode & uart_rx_in;
	assign spi_cs_b     = spi_mode ? i2c_sda_in : 1'b1;
	assign uart_rx_core = spi_mode ? 1'b1 : uart_rx_in;
	assign i2c_scl_core = spi_mode ? 1'b1 : i2c_scl_in;
	assign i2c_sda_core = spi_mode ? 1'b1 : i2c_sda_in;
	assign uart_tx_pin  = spi_mode ? spi_miso_core : uart_tx_core;
	assign uart_tx_oe   = running & (!spi_mode | !spi_cs_b);

	// ==================================================
	// Reference inputs: offset and interrupt
	logic [PHASE_W-1:0] phase_cnt_reg;
	logic [2:0]         edge_reg;

	always_ff @(posedge clk_sys or negedge rst_int_b) begin
		if (!rst_int_b) begin
			phase_cnt_reg <= '0;
			edge_reg      <= '0;
			offset_a      <= '0;
			offset_b      <= '0;
			offset_valid  <= 1'b0;
			steer_a       <= 1'b0;
			steer_b       <= 1'b0;
			ext_irq_a     <= 1'b0;
			ext_irq_b     <= 1'b0;
		end else begin
			edge_reg      <= {sync_pulse, ref_pulse_in_b, ref_pulse_in_a};
			phase_cnt_reg <= (sync_pulse & !edge_reg[2]) ? '0 : phase_cnt_reg + 1'b1;
			offset_valid  <= 1'b0;
			ext_irq_a     <= running & irq_mode & ref_pulse_in_a & !edge_reg[0];
			ext_irq_b     <= running & irq_mode & ref_pulse_in_b & !edge_reg[1];
			if (running & !irq_mode & ref_pulse_in_a & !edge_reg[0]) begin
				offset_a     <= phase_cnt_reg;
				offset_valid <= 1'b1;
				steer_a      <= steer_en & phase_cnt_reg[PHASE_W-1];
			end
			if (running & !irq_mode & ref_pulse_in_b & !edge_reg[1]) begin
				offset_b     <= phase_cnt_reg;
				offset_valid <= 1'b1;
				steer_b      <= steer_en & phase_cnt_reg[PHASE_W-1];
			end
		end
	end

	// Reference clock buffered out of the oscillator enable
	always_ff @(posedge clk_sys or negedge rst_int_b) begin
		if (!rst_int_b)
			disciplined_clk_out <= 1'b0;
		else
			disciplined_clk_out <= osc_clk_en;
	end

	// ==================================================
	// Configuration: volatile store, save on command
	wire cfg_clear = !running;
	wire cfg_wr    = running & cfg_cmd.valid & cfg_cmd.write;

	always_ff @(posedge clk_sys or negedge rst_int_b) begin
		if (!rst_int_b)
			save_config_command <= 1'b0;
		else
			save_config_command <= running & cfg_cmd.valid & cfg_cmd.save;
	end

	cfg_store #(
		.WORDS (CFG_WORDS),
		.AW    (CFG_AW)
	) u_cfg (
		.clk_sys (clk_sys),
		.clear   (cfg_clear),
		.wr_en   (cfg_wr),
		.wr_addr (cfg_cmd.addr),
		.wr_data (cfg_cmd.data),
		.rd_addr (cfg_rd_addr),
		.rd_data (cfg_rd_data)
	);
endmodule
`default_nettype wire

// [core/strap_pkg.sv]
// Package for the start-up and pin-control block.
// Assumes a 10 MHz system clock.
package strap_pkg;

	localparam int unsigned CLK_HZ          = 10000000;
	localparam int unsigned RESTART_MIN_MS  = 10;
	// Least restart width in cycles, rounded down
	localparam int unsigned RESTART_MIN_CYC =
		(RESTART_MIN_MS * (CLK_HZ / 1000) + 0);
	// Power-on hold after supply up, in cycles
	localparam int unsigned POR_HOLD_CYC    = 16;
	localparam int unsigned CFG_WORDS       = 8;
	localparam int unsigned CFG_AW          = 3;
	localparam logic [7:0]  CFG_RESET_VAL   = 8'h00;
	localparam int unsigned PHASE_W         = 16;

	typedef enum logic [1:0] {
		ST_POR   = 2'b00,
		ST_STRAP = 2'b01,
		ST_RUN   = 2'b10,
		ST_HOLD  = 2'b11
	} seq_state_t;

	typedef struct packed {
		logic spi_mode;
		logic recovery_boot;
	} strap_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic       save;
		logic [2:0] addr;
		logic [7:0] data;
	} cfg_cmd_t;

endpackage

// [test/host_board_model.sv]
// Host board model: restart and strap pins with pull-ups.
// Assumes its controls change just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_board_model (
	input  wire logic pull_restart,
	input  wire logic pull_sel,
	input  wire logic pull_tp,
	input  wire logic tp_out,
	input  wire logic tp_oe,
	output logic      restart_in_b,
	output logic      iface_sel_strap_b,
	output logic      tp_pin
);
	// Released pins float high; restart only pulsed
	assign restart_in_b      = !pull_restart;
	assign iface_sel_strap_b = !pull_sel;
	assign tp_pin            = tp_oe ? tp_out : !pull_tp;
endmodule
`default_nettype wire

// [test/reset_strap_iface_select_asserts.sv]
// Checker for the start-up and pin-control block.
// Assumes it is bound to the ports of the top module.
`timescale 1ns/1ps
`default_nettype none
module reset_strap_iface_select_asserts
	import strap_pkg::*;
#(
	parameter int unsigned RESTART_CYC = RESTART_MIN_CYC
) (
	input wire logic     clk_sys,
	input wire logic     rst_b,
	input wire logic     restart_in_b,
	input wire logic     i2c_scl_in,
	input wire logic     uart_rx_in,
	input wire logic     uart_tx_core,
	input wire logic     osc_clk_en,
	input wire cfg_cmd_t cfg_cmd,
	input wire logic     spi_sclk,
	input wire logic     spi_mosi,
	input wire logic     uart_tx_pin,
	input wire logic     disciplined_clk_out,
	input wire logic     save_config_command,
	input wire logic     core_rst_b,
	input wire logic     recovery_boot,
	input wire logic     spi_mode
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// Consecutive low cycles on the restart pin
	logic [31:0] low_cnt_reg;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) low_cnt_reg <= 32'h00000000;
		else if (restart_in_b) low_cnt_reg <= 32'h00000000;
		else if (low_cnt_reg != 32'hFFFFFFFF) low_cnt_reg <= low_cnt_reg + 32'h00000001;
	end
	sequence por_hold;
		!core_rst_b [*6];
	endsequence
	sequence save_pulse;
		save_config_command ##1 !save_config_command;
	endsequence
	a_restart_min: assert property ($fell(core_rst_b) |-> low_cnt_reg >= RESTART_CYC)
		else $error("restart taken from a short pulse");
	a_restart_taken: assert property (low_cnt_reg > RESTART_CYC + 4 |-> !core_rst_b)
		else $error("long restart pulse not taken");
	a_por_release: assert property ($rose(rst_b) |-> por_hold ##[1:40] core_rst_b)
		else $error("power-on sequence wrong");
	a_straps_held: assert property (core_rst_b && $past(core_rst_b)
		|-> $stable({spi_mode, recovery_boot}))
		else $error("strap decision changed in run");
	a_clk_copy: assert property (core_rst_b && $past(core_rst_b)
		|-> disciplined_clk_out == $past(osc_clk_en))
		else $error("reference clock copy wrong");
	a_save_cmd: assert property (cfg_cmd.valid && cfg_cmd.save && core_rst_b
		|=> save_pulse)
		else $error("save pulse wrong");
	a_spi_clock: assert property (spi_mode |-> spi_sclk == i2c_scl_in)
		else $error("spi clock not from scl pin");
	a_spi_mosi: assert property (spi_mode |-> spi_mosi == uart_rx_in)
		else $error("spi mosi not from rx pin");
	a_uart_tx: assert property (!spi_mode && core_rst_b |-> uart_tx_pin == uart_tx_core)
		else $error("uart tx pin wrong");
endmodule
bind reset_strap_iface_select reset_strap_iface_select_asserts #(.RESTART_CYC(RESTART_CYC)) u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .restart_in_b(restart_in_b), .i2c_scl_in(i2c_scl_in),
	.uart_rx_in(uart_rx_in), .uart_tx_core(uart_tx_core), .osc_clk_en(osc_clk_en),
	.cfg_cmd(cfg_cmd), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .uart_tx_pin(uart_tx_pin),
	.disciplined_clk_out(disciplined_clk_out), .save_config_command(save_config_command),
	.core_rst_b(core_rst_b), .recovery_boot(recovery_boot), .spi_mode(spi_mode));
`default_nettype wire

// [test/reset_strap_iface_select_bench.sv]
// Bench for the start-up and pin-control block.
// Assumes the host board model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module reset_strap_iface_select_bench;
	import strap_pkg::*;
	typedef struct packed {
		logic       sel;
		logic       boot;
		logic [3:0] pins;
		logic [2:0] exp;
	} row_t;
	localparam int RC = 20;
	row_t rows [4] = '{'{1'h0, 1'h0, 4'hA, 3'h1}, '{1'h1, 1'h0, 4'hA, 3'h4},
		'{1'h0, 1'h1, 4'h5, 3'h2}, '{1'h1, 1'h1, 4'h5, 3'h7}};
	logic clk_sys = 0, rst_b = 0, osc_clk_en = 0, irq_mode = 0, ref_a = 0, ref_b = 0;
	logic scl = 0, rx = 0, sda = 1, txc = 0, miso = 0, rl = 0, sl = 0, tl = 0;
	logic pg = 0, sync = 0;
	logic dclk, ov, uart_on, i2c_on, spi_on, cs_b, tx_oe, rx_c, scl_c, sda_c;
	logic [PHASE_W-1:0] oa, ob;
	logic restart_b, sel_b, tp_in, tp_out, tp_oe, irq_a, irq_b, tx_pin, sclk, mosi;
	logic save, core_rst_b, boot, spi_mode;
	logic [1:0] hits;
	logic [7:0] rdd;
	logic [2:0] rda = 3'h0;
	cfg_cmd_t cmd = '0;
	int mismatches = 0, checks_done = 0;
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) osc_clk_en <= ~osc_clk_en;
	host_board_model u_host_board_model (.pull_restart(rl), .pull_sel(sl), .pull_tp(tl),
		.tp_out(tp_out), .tp_oe(tp_oe), .restart_in_b(restart_b),
		.iface_sel_strap_b(sel_b), .tp_pin(tp_in));
	reset_strap_iface_select #(.RESTART_CYC(RC), .POR_CYC(4)) u_reset_strap_iface_select (
		.clk_sys(clk_sys), .rst_b(rst_b), .restart_in_b(restart_b), .iface_sel_strap_b(sel_b),
		.pulse_output_two_in(tp_in), .pulse_gen(pg), .pulse_output_two_out(tp_out),
		.pulse_output_two_oe(tp_oe), .sync_pulse(sync), .ref_pulse_in_a(ref_a),
		.ref_pulse_in_b(ref_b), .irq_mode(irq_mode), .steer_en(1'h0), .offset_a(oa),
		.offset_b(ob), .offset_valid(ov), .steer_a(), .steer_b(), .ext_irq_a(irq_a),
		.ext_irq_b(irq_b), .osc_clk_en(osc_clk_en), .disciplined_clk_out(dclk),
		.i2c_scl_in(scl), .uart_rx_in(rx), .i2c_sda_in(sda), .uart_tx_core(txc),
		.spi_miso_core(miso), .uart_tx_pin(tx_pin), .uart_tx_oe(tx_oe), .uart_rx_core(rx_c),
		.i2c_scl_core(scl_c), .i2c_sda_core(sda_c), .i2c_port_en(i2c_on), .uart_en(uart_on),
		.spi_sclk(sclk), .spi_mosi(mosi), .spi_cs_b(cs_b), .spi_en(spi_on), .cfg_cmd(cmd),
		.cfg_rd_addr(rda), .cfg_rd_data(rdd), .save_config_command(save),
		.core_rst_b(core_rst_b), .recovery_boot(boot), .spi_mode(spi_mode));
	// ========
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_run();
		int n = 0;
		while (core_rst_b !== 1'h1 && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		chk(8'(n < 200), 8'h01);
		@(posedge clk_sys);
		sl <= 1'h0;
		tl <= 1'h0;
		@(negedge clk_sys);
	endtask
	task automatic pull_restart(input int n);
		@(posedge clk_sys);
		rl <= 1'h1;
		repeat (n) @(posedge clk_sys);
		rl <= 1'h0;
		@(negedge clk_sys);
	endtask
	task automatic close_out();
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ========
	// Stimulus
	initial begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		close_out();
	end
	initial begin
		foreach (rows[i]) begin
			@(posedge clk_sys);
			{sl, tl, scl, rx, txc, miso} <= {rows[i].sel, rows[i].boot, rows[i].pins};
			rst_b <= 1'h0;
			repeat (16) @(posedge clk_sys);
			rst_b <= 1'h1;
			wait_run();
			chk({spi_mode, boot, tx_pin}, rows[i].exp);
			if (rows[i].sel) chk({sclk, mosi}, rows[i].pins[3:2]);
			chk({uart_on, i2c_on, spi_on}, rows[i].sel ? 8'h01 : 8'h06);
			chk({rx_c, scl_c, sda_c}, rows[i].sel ? 8'h07 : {5'h00, rows[i].pins[2], rows[i].pins[3], 1'h1});
			chk({cs_b, tx_oe}, {1'h1, !rows[i].sel});
			chk(dclk, !osc_clk_en);
			@(negedge clk_sys);
			chk(dclk, !osc_clk_en);
			$display("test row %0d done", i);
		end
		@(posedge clk_sys);
		cmd <= '{1'h1, 1'h1, 1'h0, 3'h7, 8'hA5};
		@(posedge clk_sys);
		cmd <= '{1'h1, 1'h0, 1'h1, 3'h0, 8'h00};
		rda <= 3'h7;
		@(posedge clk_sys);
		cmd <= '0;
		@(negedge clk_sys);
		chk(rdd, 8'hA5);
		chk(save, 8'h01);
		$display("test config done");
		pull_restart(RC - 3);
		repeat (4) @(negedge clk_sys);
		chk(core_rst_b, 8'h01);
		@(posedge clk_sys);
		sl <= 1'h1;
		pull_restart(RC + 5);
		chk(core_rst_b, 8'h00);
		chk(tp_oe, 8'h00);
		wait_run();
		chk({spi_mode, boot}, 8'h02);
		chk(rdd, 8'h00);
		@(posedge clk_sys);
		{sda, pg} <= 2'h1;
		@(negedge clk_sys);
		chk({cs_b, tx_oe}, 8'h01);
		chk({tp_oe, tp_in}, 8'h03);
		$display("test restart done");
		@(posedge clk_sys);
		{irq_mode, ref_a, ref_b} <= 3'h7;
		hits = 2'h0;
		repeat (4) begin
			@(negedge clk_sys);
			hits = hits | {irq_a, irq_b};
		end
		chk(hits, 8'h03);
		$display("test irq done");
		@(posedge clk_sys);
		{irq_mode, ref_a, ref_b, sync} <= 4'h1;
		repeat (5) @(posedge clk_sys);
		ref_a <= 1'h1;
		repeat (3) @(posedge clk_sys);
		ref_b <= 1'h1;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(ov, 8'h01);
		chk(oa[7:0], 8'h04);
		chk(ob[7:0], 8'h07);
		chk(oa[PHASE_W-1:8] | ob[PHASE_W-1:8], 8'h00);
		$display("test offset done");
		close_out();
	end
endmodule
`default_nettype wire
